// *** tsd_pkg.sv ***
// shared constants and helpers for the test status digital i/o block
package tsd_pkg;
    // clock and timing
    localparam int CLK_NS        = 100;
    localparam int LEAD_NS       = 1000;   // timing pulse lead and trail
    localparam int STB_NS        = 100;    // strobe width and margins
    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] LEAD_CYC =
        CNT_W'((LEAD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] STB_CYC =
        CNT_W'((STB_NS + CLK_NS - 1) / CLK_NS);
    // apb register offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_SETCFG = 8'h04;
    localparam logic [7:0] A_LOAD   = 8'h08;
    localparam logic [7:0] A_ENG    = 8'h0c;
    localparam logic [7:0] A_RES    = 8'h10;
    localparam logic [7:0] A_STEP   = 8'h14;
    localparam logic [7:0] A_INCFG0 = 8'h18;
    localparam logic [7:0] A_INCFG1 = 8'h1c;
    localparam logic [7:0] A_STAT   = 8'h20;
    // control register fields
    localparam int C_MODE = 0;    // two bits
    localparam int C_INEN = 2;
    localparam int C_GP   = 3;
    localparam int C_RUN  = 4;
    localparam int C_WAIT = 5;
    localparam int C_STEP = 6;
    localparam int C_AUTO = 7;
    localparam logic [1:0] OM_STATIC = 2'h1;
    localparam logic [1:0] OM_MUX    = 2'h2;
    // set config byte: [4:0] function, [5] active high
    localparam int SC_POL = 5;
    // input config byte: [4:0] function, [6:5] detection
    localparam int IC_DET = 5;
    localparam logic [1:0] DET_HIGH = 2'h0;
    localparam logic [1:0] DET_LOW  = 2'h1;
    localparam logic [1:0] DET_RISE = 2'h2;
    // output set functions
    localparam int OF_NONE = 0;
    localparam int OF_LOAD = 1;   // 1..4 sections a..d
    localparam int OF_SRC  = 5;
    localparam int OF_LINE = 6;
    localparam int OF_FIL  = 7;
    localparam int OF_TUBE = 8;
    localparam int OF_TST  = 9;
    localparam int OF_RES  = 10;  // 10..13 ballasts 1..4
    localparam int OF_FAIL = 14;
    localparam int OF_STLO = 15;
    localparam int OF_STHI = 16;
    localparam int OF_WAIT = 17;
    localparam int OF_TIME = 18;
    localparam int OF_N    = 19;
    // input functions
    localparam int IF_START = 1;
    localparam int IF_DIN   = 2;  // 2..5 numbered inputs 1..4
    localparam int IF_ABORT = 6;
    localparam int IF_HOLD  = 7;
    localparam int IF_FAIL  = 8;  // 8..11 ballasts, 12 all
    localparam int IF_FALL  = 12;
    localparam int IF_RCL   = 13; // 13..17 bits b0..b4
    localparam int IF_INV   = 18;
    localparam int IF_N     = 19;
    // result codes and limits
    localparam logic [3:0] RES_EXT   = 4'h6;
    localparam logic [3:0] RES_CRIT  = 4'h4;
    localparam logic [3:0] RES_FAILM = 4'h3;
    localparam logic [7:0] LOAD_MAX  = 8'h0f;
    localparam logic [3:0] MUX_LAST  = 4'h8;

    // highest-numbered pin of a set carries the lsb
    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction : rev4
endpackage : tsd_pkg

// *** tsd_in_qual.sv ***
// one digital input: synchroniser and active-condition detection
`timescale 1ns/10ps
module tsd_in_qual
    import tsd_pkg::*;
(
    input  wire logic       i_mclk,    // system clock
    input  wire logic       i_reset_n, // sync reset, active low
    input  wire logic       i_ce,      // clock enable
    input  wire logic       i_pin,     // raw input pin
    input  wire logic [1:0] i_det,     // detection kind
    output logic            o_active   // qualified active condition
);
    logic meta_r;  // first stage, read only by sync_r
    logic sync_r;  // second stage
    logic prev_r;  // previous synced level for edges

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else if (i_ce) begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_active = (i_det == DET_HIGH) ? sync_r :
                      (i_det == DET_LOW)  ? ~sync_r :
                      (i_det == DET_RISE) ? (sync_r & ~prev_r) :
                                            (~sync_r & prev_r);
endmodule : tsd_in_qual

// *** tsd_mux_seq.sv ***
// multiplexed output sequencer: address, data and strobe
`timescale 1ns/10ps
module tsd_mux_seq
    import tsd_pkg::*;
(
    input  wire logic        i_mclk,    // system clock
    input  wire logic        i_reset_n, // sync reset, active low
    input  wire logic        i_ce,      // clock enable
    input  wire logic        i_en,      // multiplexed mode selected
    input  wire logic [71:0] i_items,   // nine data bytes by address
    output logic [3:0]       o_addr,    // present address
    output logic [7:0]       o_data,    // present data byte
    output logic             o_stb      // strobe
);
    typedef enum logic [1:0] {
        MS_SETUP = 2'b00,
        MS_STB   = 2'b01,
        MS_HOLD  = 2'b11
    } tsd_ms_e;

    tsd_ms_e          st_r;   // phase
    logic [CNT_W-1:0] cnt_r;  // phase cycle count
    wire              last = (cnt_r == STB_CYC - CNT_W'(1));
    wire  [3:0]       nxt_a = (o_addr == MUX_LAST) ? '0 : o_addr + 4'h1;

    // step items with strobe framed inside stable data
    always_ff @(posedge i_mclk) begin
        // parked on the last address so the first step loads item zero
        if (!i_reset_n || (i_ce && !i_en)) begin
            st_r   <= MS_HOLD;
            cnt_r  <= '0;
            o_addr <= MUX_LAST;
            o_data <= '0;
            o_stb  <= 1'b0;
        end else if (i_ce) begin
            cnt_r <= last ? '0 : cnt_r + CNT_W'(1);
            case (st_r)
                MS_SETUP: begin
                    // data is not reloaded here: a change now would land
                    // on the strobe's rising edge and break its margin
                    if (last) begin
                        st_r  <= MS_STB;
                        o_stb <= 1'b1;
                    end
                end
                MS_STB: begin
                    if (last) begin
                        st_r  <= MS_HOLD;
                        o_stb <= 1'b0;
                    end
                end
                default: begin
                    // data kept a margin past the falling edge
                    if (last) begin
                        st_r   <= MS_SETUP;
                        o_addr <= nxt_a;
                        o_data <= i_items[nxt_a*8 +: 8];
                    end
                end
            endcase
        end
    end
endmodule : tsd_mux_seq

// *** tsd_io_top.sv ***
// test status digital i/o port: apb registers, outputs and inputs
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module tsd_io_top
    import tsd_pkg::*;
#(
    parameter int N_IN = 8           // number of input pins
)(
    input  wire logic            i_mclk,      // system clock 10 MHz
    input  wire logic            i_reset_n,   // sync reset, active low
    input  wire logic            i_ce,        // clock enable
    input  wire logic            i_psel,      // apb select
    input  wire logic            i_penable,   // apb enable
    input  wire logic            i_pwrite,    // apb write
    input  wire logic [7:0]      i_paddr,     // apb byte address
    input  wire logic [31:0]     i_pwdata,    // apb write data
    output logic      [31:0]     o_prdata,    // apb read data
    output logic                 o_pready,    // apb ready
    output logic                 o_pslverr,   // apb error
    input  wire logic [N_IN-1:0] i_din,       // input pins, bit0 = pin 17
    output logic      [15:0]     o_dout,      // output pins, bit0 = pin 1
    output logic                 o_start,     // start pulse
    output logic      [3:0]      o_din_match, // numbered inputs satisfied
    output logic                 o_abort,     // abort request
    output logic                 o_hold,      // hold request
    output logic      [3:0]      o_ext_fail,  // external fail per ballast
    output logic                 o_recall,    // recall pulse
    output logic      [4:0]      o_recall_code // store number to recall
);
    // software registers
    logic [7:0]  ctrl_r;     // mode, enables, sequencer state
    logic [31:0] setcfg_r;   // four set config bytes
    logic [31:0] load_r;     // four load step values
    logic [15:0] eng_r;      // source, line, filament, tube
    logic [19:0] res_r;      // results [15:0], wait fail [19:16]
    logic [7:0]  step_r;     // step code
    logic [63:0] incfg_r;    // eight input config bytes
    logic [31:0] prdata_r;   // read data captured at setup
    logic        armed_r;    // start rearmed after release
    logic [4:0]  rc_prev_r;  // last recall code seen
    logic [15:0] shown_r;    // static pins past the pulse guard
    logic        pulse_r;    // timing pulse level
    logic [CNT_W-1:0] tcnt_r; // pulse phase counter

    typedef enum logic [1:0] {
        TP_IDLE  = 2'b00,
        TP_LEAD  = 2'b01,
        TP_TRAIL = 2'b11
    } tsd_tp_e;
    tsd_tp_e tp_r;           // timing pulse phase

    // apb decode
    wire acc   = i_psel & i_penable;
    wire wr    = acc & i_pwrite & i_ce;
    wire h_ctl = (i_paddr == A_CTRL);
    wire h_set = (i_paddr == A_SETCFG);
    wire h_ld  = (i_paddr == A_LOAD);
    wire h_eng = (i_paddr == A_ENG);
    wire h_res = (i_paddr == A_RES);
    wire h_stp = (i_paddr == A_STEP);
    wire h_ic0 = (i_paddr == A_INCFG0);
    wire h_ic1 = (i_paddr == A_INCFG1);
    wire h_st  = (i_paddr == A_STAT);
    wire hit   = h_ctl | h_set | h_ld | h_eng | h_res | h_stp |
                 h_ic0 | h_ic1 | h_st;

    // control fields
    wire [1:0] omode = ctrl_r[C_MODE +: 2];
    wire gp     = ctrl_r[C_GP];
    wire run    = ctrl_r[C_RUN];
    wire pause  = ctrl_r[C_WAIT];
    wire stepon = ctrl_r[C_STEP];

    // input qualification and function decode
    logic [N_IN-1:0] act;              // qualified active per pin
    logic [IF_N-1:0] fn_oh [N_IN];     // one-hot function per pin
    logic [N_IN-1:0] col   [IF_N];     // pins assigned per function
    logic [IF_N-1:0] f_any;            // any assigned pin active
    logic [IF_N-1:0] f_all;            // assigned and all active
    genvar g, f;
    generate
        for (g = 0; g < N_IN; g++) begin : g_in
            wire [4:0] fn = incfg_r[g*8 +: 5];
            tsd_in_qual u_q (
                .i_mclk    (i_mclk),
                .i_reset_n (i_reset_n),
                .i_ce      (i_ce),
                .i_pin     (i_din[g]),
                .i_det     (incfg_r[g*8 + IC_DET +: 2]),
                .o_active  (act[g])
            );
            assign fn_oh[g] = (fn < 5'(IF_N)) ? IF_N'(1) << fn : '0;
        end
        for (f = 0; f < IF_N; f++) begin : g_fn
            for (g = 0; g < N_IN; g++) begin : g_col
                assign col[f][g] = fn_oh[g][f];
            end
        end
    endgenerate

    // invalidate and global enable gate every other input
    wire inv_any = ctrl_r[C_INEN] & |(col[IF_INV] & act);
    wire [N_IN-1:0] eff = act & {N_IN{ctrl_r[C_INEN] & ~inv_any}};
    generate
        for (f = 0; f < IF_N; f++) begin : g_comb
            assign f_any[f] = |(col[f] & eff);
            // numbered inputs need every assigned pin
            assign f_all[f] = (|col[f]) & (&(~col[f] | eff));
        end
    endgenerate

    wire fail_any = |f_any[IF_FAIL +: 5];
    // all start inputs, rearmed, not blocked
    wire start_ok = f_all[IF_START] & armed_r & ~run & ~f_any[IF_ABORT] &
                    ~f_any[IF_HOLD] & ~fail_any;
    // per-ballast fail or the all-ballast fail
    wire [3:0] xfail = f_any[IF_FAIL +: 4] | {4{f_any[IF_FALL]}};
    wire [4:0] rc    = f_any[IF_RCL +: 5];
    wire rc_valid    = ctrl_r[C_INEN] & ~inv_any;

    // register writes; external fail set wins over a software write
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_r   <= '0;
            setcfg_r <= '0;
            load_r   <= '0;
            eng_r    <= '0;
            res_r    <= '0;
            step_r   <= '0;
            incfg_r  <= '0;
        end else if (i_ce) begin
            if (wr && h_ctl) ctrl_r   <= i_pwdata[7:0];
            if (wr && h_set) setcfg_r <= i_pwdata;
            if (wr && h_ld)  load_r   <= i_pwdata;
            if (wr && h_eng) eng_r    <= i_pwdata[15:0];
            if (wr && h_res) res_r    <= i_pwdata[19:0];
            if (wr && h_stp) step_r   <= i_pwdata[7:0];
            if (wr && h_ic0) incfg_r[31:0]  <= i_pwdata;
            if (wr && h_ic1) incfg_r[63:32] <= i_pwdata;
            for (int b = 0; b < 4; b++) begin
                if (xfail[b]) res_r[b*4 +: 4] <= RES_EXT;
            end
        end
    end

    // input-side outputs; registered so they come from flops
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            armed_r       <= 1'b1;
            rc_prev_r     <= '0;
            o_start       <= 1'b0;
            o_recall      <= 1'b0;
            o_recall_code <= '0;
            o_din_match   <= '0;
            o_abort       <= 1'b0;
            o_hold        <= 1'b0;
            o_ext_fail    <= '0;
        end else if (i_ce) begin
            // rearm only once start inputs release
            if (start_ok)
                armed_r <= 1'b0;
            else if (!f_all[IF_START])
                armed_r <= 1'b1;
            o_start <= start_ok;
            // recall on a change to a nonzero code
            o_recall <= 1'b0;
            if (rc_valid) begin
                rc_prev_r <= rc;
                if (rc != rc_prev_r && rc != '0) begin
                    o_recall      <= 1'b1;
                    o_recall_code <= rc;
                end
            end
            o_din_match <= f_all[IF_DIN +: 4];
            o_abort     <= f_any[IF_ABORT];
            o_hold      <= f_any[IF_HOLD];
            o_ext_fail  <= xfail;
        end
    end

    // data items in nibbles
    logic [3:0] item [OF_N];
    logic [3:0] testing, failf;
    generate
        for (g = 0; g < 4; g++) begin : g_bal
            wire [3:0] r  = res_r[g*4 +: 4];
            wire [7:0] lv = load_r[g*8 +: 8];
            assign item[OF_LOAD + g] = (lv > LOAD_MAX) ? '0 : lv[3:0];
            assign item[OF_RES + g] = r;
            assign testing[g] = gp | (run & ~f_any[IF_ABORT] &
                                      (r < RES_CRIT));
            assign failf[g] = gp | (r >= RES_FAILM);
        end
    endgenerate

    // step code zero when idle or general-purpose
    wire [7:0] stepv = (gp | ~stepon) ? '0 : step_r;
    assign item[OF_NONE] = '0;
    // engage sets; filament and tube forced in general-purpose modes
    assign item[OF_SRC]  = eng_r[3:0];
    assign item[OF_LINE] = eng_r[7:4];
    assign item[OF_FIL]  = gp ? {4{ctrl_r[C_AUTO]}} : eng_r[11:8];
    assign item[OF_TUBE] = gp ? {4{ctrl_r[C_AUTO]}} : eng_r[15:12];
    assign item[OF_TST]  = testing;
    assign item[OF_FAIL] = failf;
    assign item[OF_STLO] = stepv[3:0];
    assign item[OF_STHI] = stepv[7:4];
    // wait fail only during an operator_pause_step
    assign item[OF_WAIT] = (gp | ~pause) ? '0 : res_r[19:16];
    assign item[OF_TIME] = '0;

    // static sets
    logic [15:0] tgt;       // static pins, timing pins held zero
    logic [15:0] tmask;     // pins carrying a timing pulse
    logic [15:0] tpins;     // timing pulse pins with polarity
    generate
        for (g = 0; g < 4; g++) begin : g_set
            wire [4:0] fn  = setcfg_r[g*8 +: 5];
            wire       pol = setcfg_r[g*8 + SC_POL];
            wire       tim = (fn == 5'(OF_TIME));
            wire [3:0] v   = (fn < 5'(OF_N)) ? item[fn] : '0;
            // polarity; none shows the inactive level
            wire [3:0] lvl = pol ? v : ~v;
            // highest pin of the set is the lsb
            assign tgt[15-g*4 -: 4]   = tim ? '0 : rev4(lvl);
            // only the highest pin of a timing set
            assign tmask[15-g*4 -: 4] = {tim, 3'b000};
            assign tpins[15-g*4 -: 4] = {tim & (pol ~^ pulse_r), 3'b000};
        end
    endgenerate
    wire any_tim = |tmask;
    wire wait_t  = (tcnt_r == LEAD_CYC - CNT_W'(1));

    // pulse asserts a lead before and drops a trail after
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            tp_r    <= TP_IDLE;
            tcnt_r  <= '0;
            pulse_r <= 1'b0;
            shown_r <= '0;
        end else if (i_ce) begin
            case (tp_r)
                TP_IDLE: begin
                    tcnt_r <= '0;
                    if (!any_tim) begin
                        // no timing set: changes pass at once
                        shown_r <= tgt;
                    end else if (tgt != shown_r) begin
                        pulse_r <= 1'b1;
                        tp_r    <= TP_LEAD;
                    end
                end
                TP_LEAD: begin
                    tcnt_r <= tcnt_r + CNT_W'(1);
                    if (wait_t) begin
                        tcnt_r  <= '0;
                        shown_r <= tgt;
                        tp_r    <= TP_TRAIL;
                    end
                end
                default: begin
                    // later changes wait for the next pulse
                    tcnt_r <= tcnt_r + CNT_W'(1);
                    if (wait_t) begin
                        pulse_r <= 1'b0;
                        tp_r    <= TP_IDLE;
                    end
                end
            endcase
        end
    end

    wire [71:0] mux_items = {
        4'h0, item[OF_WAIT],
        stepv,
        failf, item[OF_RES + 3],
        item[OF_RES + 2], item[OF_RES + 1],
        item[OF_RES], testing,
        item[OF_TUBE], item[OF_FIL],
        item[OF_LINE], item[OF_SRC],
        item[OF_LOAD + 3], item[OF_LOAD + 2],
        item[OF_LOAD + 1], item[OF_LOAD]};
    wire [3:0] m_addr;
    wire [7:0] m_data;
    wire       m_stb;
    wire       mux_on = (omode == OM_MUX);
    tsd_mux_seq u_mux (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_en      (mux_on),
        .i_items   (mux_items),
        .o_addr    (m_addr),
        .o_data    (m_data),
        .o_stb     (m_stb)
    );
    // active-high data, address and strobe on pins
    wire [15:0] mux_pins = {rev4(m_data[3:0]), rev4(m_data[7:4]),
                            rev4(m_addr), m_stb, 3'b000};
    wire [15:0] stat_pins = (shown_r & ~tmask) | tpins;

    // output pins; settings kept while off
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_dout <= '1;
        end else if (i_ce) begin
            if (omode == OM_STATIC)
                o_dout <= stat_pins;
            else if (mux_on)
                o_dout <= mux_pins;
            else
                o_dout <= '1;
        end
    end

    // read data, captured in the setup cycle
    wire [31:0] rdata =
        h_ctl ? {24'h000000, ctrl_r} :
        h_set ? setcfg_r :
        h_ld  ? load_r :
        h_eng ? {16'h0000, eng_r} :
        h_res ? {12'h000, res_r} :
        h_stp ? {24'h000000, step_r} :
        h_ic0 ? incfg_r[31:0] :
        h_ic1 ? incfg_r[63:32] :
        h_st  ? {o_dout, inv_any, armed_r, o_hold, o_abort,
                 o_din_match, act} :
        32'h00000000;

    // apb read path; zero wait states
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n)
            prdata_r <= '0;
        else if (i_ce && i_psel && !i_penable)
            prdata_r <= rdata;
    end
    assign o_prdata  = prdata_r;
    assign o_pready  = 1'b1;
    assign o_pslverr = acc & ~hit;
endmodule : tsd_io_top

// *** tsd_io_assertions.sv ***
// checker for the digital i/o port outputs and its apb replies
`timescale 1ns/10ps
module tsd_io_assertions (
    input wire logic        i_mclk, i_reset_n, i_psel, i_penable,
    input wire logic [7:0]  i_paddr,
    input wire logic        o_pslverr, o_start, o_abort, o_hold, o_recall,
    input wire logic [3:0]  o_ext_fail,
    input wire logic [15:0] o_dout,
    input wire logic [4:0]  o_recall_code
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_reset_pins_high: assert property ($rose(i_reset_n) |->
        o_dout == 16'hffff) else $error("pins not high after reset");
    a_start_unblocked: assert property (o_start |->
        !o_abort && !o_hold && o_ext_fail == 4'h0)
        else $error("start while blocked");
    a_start_single: assert property (o_start |=> !o_start)
        else $error("start pulse too long");
    a_recall_single: assert property (o_recall |=> !o_recall)
        else $error("recall pulse too long");
    a_recall_nonzero: assert property (o_recall |->
        o_recall_code != 5'h00) else $error("recall of store zero");
    a_code_held: assert property ($changed(o_recall_code) |->
        o_recall) else $error("recall code moved without recall");
    a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("error outside access phase");
    a_err_unmapped: assert property (i_psel && i_penable &&
        i_paddr > 8'h20 |-> o_pslverr) else $error("unmapped not refused");
endmodule : tsd_io_assertions

// *** tsd_fixture.sv ***
// fixture model that drives the eight input pins
`timescale 1ns/10ps
module tsd_fixture #(
    parameter int HOLD = 4 // shortened minimum level time
)(
    input  wire logic       i_lclk, // fixture clock
    input  wire logic [7:0] i_want, // levels asked for by the bench
    output logic      [7:0] o_pins  // pins toward the port
);
    int cnt = 0; // time spent at the present level
    initial o_pins = 8'h00;
    always @(posedge i_lclk) begin
        if (cnt < HOLD) cnt <= cnt + 1;
        else if (i_want != o_pins) begin
            o_pins <= i_want;
            cnt <= 0;
        end
    end
endmodule : tsd_fixture

// *** test_tsd_io_top.sv ***
// testbench for the test status digital i/o port
`timescale 1ns/10ps
module test_tsd_io_top;
    import tsd_pkg::*;
    logic i_mclk, i_reset_n, i_ce, i_psel, i_penable, i_pwrite, lclk;
    logic o_pready, o_pslverr, o_start, o_abort, o_hold, o_recall, serr, hit;
    logic [7:0] i_paddr, i_din, want;
    logic [31:0] i_pwdata, o_prdata;
    logic [15:0] o_dout;
    logic [3:0] o_din_match, o_ext_fail;
    logic [4:0] o_recall_code;
    logic [31:0] rdat;   // read data of the last transfer
    logic [15:0] prev;   // pins one edge earlier
    int t1, t2, t3;      // timing pulse event cycles
    int err_count = 0, samples_checked = 0;
    tsd_io_top i_tsd_io_top (.*);
    tsd_fixture i_tsd_fixture (.i_lclk(lclk), .i_want(want), .o_pins(i_din));
    initial begin i_mclk = 0; forever #50 i_mclk = ~i_mclk; end
    // fixture clock, phase unrelated to the system clock
    initial begin lclk = 0; #37; forever #400 lclk = ~lclk; end
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer; a spare edge keeps strobes from double writes
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_mclk); i_penable <= 1;
        for (int n = 0; n < 20; n++) begin
            @(posedge i_mclk);
            if (o_pready === 1'b1) break;
            if (n == 19) begin err_count++; results(); end
        end
        serr = o_pslverr;
        rdat = o_prdata;
        i_psel <= 0; i_penable <= 0;
        @(posedge i_mclk);
    endtask : apb
    // watch for start (0), recall (1) or abort (2) within a bound
    task automatic pulse(input int k, input bit must);
        hit = 0;
        for (int n = 0; n < 200 && !(hit && must); n++) begin
            @(posedge i_mclk);
            hit |= (k == 0) ? o_start === 1'b1 :
                   (k == 1) ? o_recall === 1'b1 : o_abort === 1'b1;
        end
        if (must && !hit) begin err_count++; results(); end
    endtask : pulse
    initial begin
        {i_reset_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        i_ce = 1; want = 8'h00;
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1;
        chk("reset", o_dout, 16'hffff);
        apb(1, A_SETCFG, 32'h002e0a21);
        apb(1, A_LOAD, 32'h5);
        apb(1, A_RES, 32'h3);
        apb(1, A_CTRL, 32'h5);
        repeat (4) @(posedge i_mclk);
        chk("static", o_dout, 16'ha38f);
        apb(1, A_LOAD, 32'h1f);
        apb(1, A_RES, 32'h6);
        repeat (4) @(posedge i_mclk);
        chk("range", o_dout, 16'h098f);
        apb(1, A_CTRL, 32'h4);
        repeat (4) @(posedge i_mclk);
        chk("off", o_dout, 16'hffff);
        apb(1, A_CTRL, 32'h5);
        repeat (4) @(posedge i_mclk);
        chk("kept", o_dout, 16'h098f);
        apb(0, 8'h40, 0);
        chk("slverr", serr, 1);
        apb(0, A_CTRL, 0);
        chk("read", rdat, 32'h5);
        // mux: address four framed by stable setup and hold cycles
        apb(1, A_CTRL, 32'h6);
        for (int n = 0; n < 60 && o_dout[7:3] != 5'h05; n++) begin
            prev = o_dout;
            @(posedge i_mclk);
        end
        chk("mux setup", prev, 16'h0620);
        chk("mux", o_dout, 16'h0628);
        @(posedge i_mclk);
        chk("mux hold", o_dout, 16'h0620);
        // static with a timing pulse on pin 4
        apb(1, A_SETCFG, 32'h322e0a21);
        apb(1, A_CTRL, 32'h5);
        repeat (30) @(posedge i_mclk);
        apb(1, A_RES, 32'h3);
        t1 = 0; t2 = 0; t3 = 0;
        for (int n = 1; n < 40; n++) begin
            @(posedge i_mclk);
            if (!t1 && o_dout[3]) t1 = n;
            if (!t2 && o_dout[11:8] == 4'h3) t2 = n;
            if (t1 && !t3 && !o_dout[3]) t3 = n;
        end
        chk("lead", t1 && t2 - t1 >= LEAD_CYC, 1);
        chk("trail", t2 && t3 - t2 >= LEAD_CYC, 1);
        apb(1, A_CTRL, 32'hd);
        repeat (30) @(posedge i_mclk);
        chk("general", o_dout, 16'h03f0);
        $display("outputs done");
        apb(1, A_INCFG0, 32'h070d0601);
        want <= 8'h01;
        pulse(0, 1);
        want <= 8'h02;
        pulse(2, 1);
        chk("abort", o_abort, 1);
        want <= 8'h03;
        pulse(0, 0);
        chk("blocked", hit, 0);
        want <= 8'h04;
        pulse(1, 1);
        chk("code", o_recall_code, 5'h01);
        want <= 8'h00;
        pulse(1, 0);
        chk("zero", hit, 0);
        // hold, fail ballast two, two pins on input one, invalidate
        apb(1, A_INCFG1, 32'h12020209);
        want <= 8'h78;
        repeat (60) @(posedge i_mclk);
        chk("hold", o_hold, 1);
        chk("xfail", o_ext_fail, 4'h2);
        chk("din", o_din_match, 4'h1);
        apb(0, A_RES, 0);
        chk("xres", rdat, 32'h63);
        want <= 8'h38;
        repeat (60) @(posedge i_mclk);
        chk("din part", o_din_match, 4'h0);
        want <= 8'hf8;
        repeat (60) @(posedge i_mclk);
        chk("invalid", {o_hold, o_ext_fail, o_din_match}, 0);
        $display("inputs done");
        results();
    end
endmodule : test_tsd_io_top
bind tsd_io_top tsd_io_assertions i_chk (.*);
